// [src/mtca_pkg.sv]
// Purpose: Shared constants for the module timing/capability advertisement link
// Assumes: One 125 MHz clock shared by both ends
// Notes: Advertisement byte map, field positions, host register map
package mtca_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int NS_PER_US     = 1000;
	localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;

	// Advertisement byte offsets
	localparam logic [7:0] OFS_SELECT_WAIT   = 8'h8F;
	localparam logic [7:0] OFS_DP_DURATIONS  = 8'h90;
	localparam logic [7:0] OFS_CHAR_A        = 8'h91;
	localparam logic [7:0] OFS_TEMP_UPPER    = 8'h92;
	localparam logic [7:0] OFS_TEMP_LOWER    = 8'h93;
	localparam logic [7:0] OFS_LATENCY_HI    = 8'h94;
	localparam logic [7:0] OFS_LATENCY_LO    = 8'h95;
	localparam logic [7:0] OFS_SUPPLY_LOWER  = 8'h96;
	localparam logic [7:0] OFS_RXTX_TYPES    = 8'h97;
	localparam logic [7:0] OFS_BYPASS_SAVING = 8'h98;
	localparam logic [7:0] OFS_AMP_TXEQ      = 8'h99;
	localparam logic [7:0] OFS_RX_CURSORS    = 8'h9A;

	// Field positions
	localparam int WAIT_EXP_LSB   = 5;
	localparam int WAIT_EXP_W     = 3;
	localparam int WAIT_MANT_W    = 5;
	localparam int NIBBLE_W       = 4;
	localparam int DEINIT_LSB     = 4;
	localparam int COOLED_BIT     = 7;
	localparam int SYNC_GRP_LSB   = 5;
	localparam int PPS_BIT        = 4;
	localparam int TPAGE_BIT      = 3;
	localparam int DETECTOR_BIT   = 7;
	localparam int RXEQ_KIND_LSB  = 5;
	localparam int PWR_METRIC_BIT = 4;
	localparam int LOS_METRIC_BIT = 3;
	localparam int FAST_LOS_BIT   = 2;
	localparam int FAST_OFF_BIT   = 1;
	localparam int GLOBAL_OFF_BIT = 0;
	localparam int AMP_SUP_LSB    = 4;
	localparam int LANES          = 8;

	// Duration codes
	localparam logic [3:0] DUR_UNDER_1MS   = 4'h0;
	localparam logic [3:0] DUR_50MIN_OVER  = 4'hD;
	localparam logic [3:0] DUR_RESERVED_LO = 4'hE;

	// Host register map (APB byte addresses)
	localparam logic [7:0] HREG_CTRL   = 8'h00;
	localparam logic [7:0] HREG_STATUS = 8'h04;
	localparam logic [7:0] HREG_RDATA  = 8'h08;
	localparam logic [7:0] HREG_WAIT   = 8'h0C;
	localparam int CTRL_START_BIT  = 0;
	localparam int CTRL_WRITE_BIT  = 1;
	localparam int CTRL_ADDR_LSB   = 8;
	localparam int CTRL_WDATA_LSB  = 16;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_DONE_BIT   = 1;
	localparam int STAT_KNOWN_BIT  = 2;
	localparam int WAIT_US_W       = 12;
	localparam int WAIT_CYC_W      = 20;
	localparam logic [11:0] WAIT_US_RESET = 12'hF80;
endpackage

// [src/mtca_if.sv]
// Purpose: Management link between host controller and module advertisement bank
// Assumes: Both ends on clk
// Notes: req held by host until ack pulse
`timescale 1ns/100ps
interface mtca_if (input wire logic clk);
	logic       module_select_line;
	logic       req;
	logic       wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       ack;
	logic [7:0] rdata;

	modport host_mp (output module_select_line, output req, output wr, output addr, output wdata,
		input ack, input rdata);
	modport dev_mp (input module_select_line, input req, input wr, input addr, input wdata,
		output ack, output rdata);
endinterface

// [src/mtca_module_end.sv]
// Purpose: Module-side read-only advertisement bank and Tx disable fan-out
// Assumes: Host keeps select timing; link signals come from logic on clk
// Notes: Advertised values are fixed by parameters at build time
`timescale 1ns/100ps
module mtca_module_end
	import mtca_pkg::*;
#(
	parameter logic [2:0] WAIT_EXP        = 3'h1,
	parameter logic [4:0] WAIT_MANT       = 5'h02,
	parameter logic [3:0] DEINIT_CODE     = 4'h3,
	parameter logic [3:0] INIT_CODE       = 4'h4,
	parameter logic       COOLED          = 1'h0,
	parameter logic [1:0] SYNC_GROUPING   = 2'h0,
	parameter logic       PPS_SUPPORT     = 1'h0,
	parameter logic       TPAGE_SUPPORT   = 1'h0,
	parameter logic [2:0] AUX_SOURCES     = 3'h0,
	parameter logic [7:0] TEMP_UPPER      = 8'h46,
	parameter logic [7:0] TEMP_LOWER      = 8'h00,
	parameter logic [15:0] LATENCY        = 16'h0000,
	parameter logic [7:0] SUPPLY_LOWER    = 8'h00,
	parameter logic       DETECTOR_APD    = 1'h0,
	parameter logic [1:0] RXEQ_KIND       = 2'h0,
	parameter logic       PWR_METRIC_AVG  = 1'h0,
	parameter logic       LOS_METRIC_AVG  = 1'h0,
	parameter logic       FAST_LOS        = 1'h0,
	parameter logic       FAST_OFF        = 1'h0,
	parameter logic       GLOBAL_OFF      = 1'h0,
	parameter logic [7:0] BYPASS_SAVING   = 8'h00,
	parameter logic [3:0] AMP_SUPPORT     = 4'h1,
	parameter logic [3:0] TX_EQ_CEILING   = 4'h0,
	parameter logic [3:0] POST_CEILING    = 4'h0,
	parameter logic [3:0] PRE_CEILING     = 4'h0
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	mtca_if.dev_mp                 link,
	input  wire logic [LANES-1:0]  tx_lane_output_off,
	output logic      [LANES-1:0]  tx_out_disabled
);
	logic       ack_r;
	logic [7:0] rdata_r;
	logic [LANES-1:0] tx_off_r;
	logic       take;

	assign link.ack   = ack_r;
	assign link.rdata = rdata_r;
	assign tx_out_disabled = tx_off_r;

	// Duration codes 1110b and 1111b are reserved; clamp a bad build value to the top code
	function automatic logic [3:0] legal_dur(input logic [3:0] c);
		legal_dur = (c >= DUR_RESERVED_LO) ? DUR_50MIN_OVER : c;
	endfunction

	function automatic logic [7:0] advert(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			OFS_SELECT_WAIT:   v = {WAIT_EXP, WAIT_MANT};
			OFS_DP_DURATIONS:  v = {legal_dur(DEINIT_CODE), legal_dur(INIT_CODE)};
			OFS_CHAR_A: begin
				v[COOLED_BIT] = COOLED;
				v[SYNC_GRP_LSB +: 2] = SYNC_GROUPING;
				v[PPS_BIT] = PPS_SUPPORT;
				v[TPAGE_BIT] = TPAGE_SUPPORT;
				v[2:0] = AUX_SOURCES;
			end
			OFS_TEMP_UPPER:    v = TEMP_UPPER;
			OFS_TEMP_LOWER:    v = TEMP_LOWER;
			OFS_LATENCY_HI:    v = LATENCY[15:8];
			OFS_LATENCY_LO:    v = LATENCY[7:0];
			OFS_SUPPLY_LOWER:  v = SUPPLY_LOWER;
			OFS_RXTX_TYPES: begin
				v[DETECTOR_BIT] = DETECTOR_APD;
				v[RXEQ_KIND_LSB +: 2] = RXEQ_KIND;
				v[PWR_METRIC_BIT] = PWR_METRIC_AVG;
				v[LOS_METRIC_BIT] = LOS_METRIC_AVG;
				v[FAST_LOS_BIT] = FAST_LOS;
				v[FAST_OFF_BIT] = FAST_OFF;
				v[GLOBAL_OFF_BIT] = GLOBAL_OFF;
			end
			OFS_BYPASS_SAVING: v = BYPASS_SAVING;
			OFS_AMP_TXEQ:      v = {AMP_SUPPORT, TX_EQ_CEILING};
			OFS_RX_CURSORS:    v = {POST_CEILING, PRE_CEILING};
			default:           v = 8'h00;
		endcase
		advert = v;
	endfunction

	// No second ack while the host still holds req from the last one
	assign take = link.module_select_line & link.req & ~ack_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_r <= 1'b0;
		end else if (ce) begin
			ack_r <= take;
		end
	end

	// Writes are acknowledged but never stored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else if (ce && take) begin
			rdata_r <= link.wr ? 8'h00 : advert(link.addr);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_off_r <= '0;
		end else if (ce) begin
			tx_off_r <= GLOBAL_OFF ? {LANES{|tx_lane_output_off}} : tx_lane_output_off;
		end
	end
endmodule // mtca_module_end

// [src/mtca_host_end.sv]
// Purpose: Host controller running single-byte link transfers on APB orders
// Assumes: APB master with zero-latency psel; module end on the same clk
// Notes: Select setup and hold use the learned wait, else a safe default
`timescale 1ns/100ps
module mtca_host_end
	import mtca_pkg::*;
#(
	parameter logic [11:0] DFLT_WAIT_US = WAIT_US_RESET
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	mtca_if.host_mp          link
);
	typedef enum logic [1:0] {H_IDLE, H_SETUP, H_XFER, H_HOLD} mtca_hstate_type;

	mtca_hstate_type        st_r;
	logic [WAIT_CYC_W-1:0]  cnt_r;
	logic [WAIT_US_W-1:0]   wait_us_r;
	logic                   known_r;
	logic                   done_r;
	logic                   sel_r, req_r, wr_r;
	logic [7:0]             addr_r, wdata_r, rbyte_r;
	logic [31:0]            prdata_r;
	logic                   pready_r;
	logic                   wr_acc, start, done_set;
	logic [WAIT_CYC_W-1:0]  wait_cyc;

	assign link.module_select_line = sel_r;
	assign link.req   = req_r;
	assign link.wr    = wr_r;
	assign link.addr  = addr_r;
	assign link.wdata = wdata_r;
	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = 1'b0;

	assign wr_acc   = psel & penable & pready_r & pwrite;
	assign start    = wr_acc & (paddr == HREG_CTRL) & pwdata[CTRL_START_BIT] & (st_r == H_IDLE);
	assign done_set = (st_r == H_HOLD) && (cnt_r == '0);
	assign wait_cyc = WAIT_CYC_W'(wait_us_r * CYC_PER_US);

	// No wait states: read data is captured in setup, presented in access
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_r <= 1'b0;
		end else if (ce) begin
			pready_r <= psel & ~penable;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata_r <= 32'h0000_0000;
		end else if (ce && psel && !penable) begin
			unique case (paddr)
				HREG_STATUS: prdata_r <= {29'h0, known_r, done_r, st_r != H_IDLE};
				HREG_RDATA:  prdata_r <= {24'h0, rbyte_r};
				HREG_WAIT:   prdata_r <= {20'h0, wait_us_r};
				default:     prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			done_r <= 1'b0;
		end else if (ce) begin
			if (done_set) begin
				done_r <= 1'b1;
			end else if (wr_acc && paddr == HREG_STATUS && pwdata[STAT_DONE_BIT]) begin
				done_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_r    <= 1'b0;
			addr_r  <= 8'h00;
			wdata_r <= 8'h00;
		end else if (ce && start) begin
			wr_r    <= pwdata[CTRL_WRITE_BIT];
			addr_r  <= pwdata[CTRL_ADDR_LSB +: 8];
			wdata_r <= pwdata[CTRL_WDATA_LSB +: 8];
		end
	end

	// Learn the wait from the select wait byte; zero mantissa falls back to the default
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_us_r <= DFLT_WAIT_US;
			known_r   <= 1'b0;
			rbyte_r   <= 8'h00;
		end else if (ce && st_r == H_XFER && link.ack) begin
			rbyte_r <= link.rdata;
			if (!wr_r && addr_r == OFS_SELECT_WAIT) begin
				if (link.rdata[WAIT_MANT_W-1:0] != '0) begin
					wait_us_r <= WAIT_US_W'({7'h0, link.rdata[WAIT_MANT_W-1:0]}
						<< link.rdata[WAIT_EXP_LSB +: WAIT_EXP_W]);
					known_r   <= 1'b1;
				end else begin
					wait_us_r <= DFLT_WAIT_US;
					known_r   <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r  <= H_IDLE;
			cnt_r <= '0;
			sel_r <= 1'b0;
			req_r <= 1'b0;
		end else if (ce) begin
			unique case (st_r)
				H_IDLE: begin
					if (start) begin
						st_r  <= H_SETUP;
						sel_r <= 1'b1;
						cnt_r <= wait_cyc;
					end
				end
				H_SETUP: begin
					if (cnt_r == '0) begin
						st_r  <= H_XFER;
						req_r <= 1'b1;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				H_XFER: begin
					if (link.ack) begin
						st_r  <= H_HOLD;
						req_r <= 1'b0;
						cnt_r <= wait_cyc;
					end
				end
				H_HOLD: begin
					if (cnt_r == '0) begin
						st_r  <= H_IDLE;
						sel_r <= 1'b0;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
			endcase
		end
	end
endmodule // mtca_host_end

// [verification/mtca_link_checker.sv]
// Purpose: Link protocol checks between host and module ends
// Assumes: One clk, sys_rst synchronous active high
// Notes: MIN_W is the shortest select wait the bench programs
`timescale 1ns/100ps
module mtca_link_checker
	import mtca_pkg::*;
#(
	parameter logic [7:0] WAIT_BYTE = 8'h22,
	parameter int MIN_W = 250
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic module_select_line,
	input wire logic req,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic ack,
	input wire logic [7:0] rdata
);
	logic [19:0] sel_cnt_r;
	logic [19:0] hold_cnt_r;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Saturate so a long hold cannot wrap under the limit
	always_ff @(posedge clk) begin
		if (sys_rst || !module_select_line)
			sel_cnt_r <= 20'h0;
		else if (sel_cnt_r != 20'hFFFFF)
			sel_cnt_r <= sel_cnt_r + 20'h1;
	end
	always_ff @(posedge clk) begin
		if (sys_rst || ack)
			hold_cnt_r <= 20'h0;
		else if (hold_cnt_r != 20'hFFFFF)
			hold_cnt_r <= hold_cnt_r + 20'h1;
	end
	a_req_in_select: assert property (req |-> module_select_line)
		else $error("request outside select");
	a_setup_wait: assert property ($rose(req) |-> sel_cnt_r >= MIN_W)
		else $error("select setup too short");
	a_hold_wait: assert property ($fell(module_select_line) |-> !req && hold_cnt_r >= MIN_W)
		else $error("select hold too short");
	a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(wr))
		else $error("request dropped early");
	a_ack_prompt: assert property (module_select_line && req && !ack |=> ack ##1 !ack)
		else $error("ack not one cycle after take");
	a_rdata_moves: assert property ($changed(rdata) |-> ack)
		else $error("rdata moved without ack");
	a_wait_byte: assert property (ack && !wr && addr == OFS_SELECT_WAIT |-> rdata == WAIT_BYTE)
		else $error("wait byte wrong");
	a_dur_codes: assert property (ack && !wr && addr == OFS_DP_DURATIONS |->
		rdata[7:4] < DUR_RESERVED_LO && rdata[3:0] < DUR_RESERVED_LO)
		else $error("reserved duration code");
	a_write_void: assert property (ack && wr |-> rdata == 8'h00)
		else $error("write returned data");
endmodule // mtca_link_checker

// [verification/module_timing_capability_advert_test.sv]
// Purpose: End-to-end bench for host controller and advertisement bank
// Assumes: Both ends on clk; this bench is the APB master
// Notes: Short default wait keeps the first transfer brief
`timescale 1ns/100ps
module module_timing_capability_advert_test
	import mtca_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] lane_off = 8'h00;
	logic [7:0] lane_dis;
	logic [7:0] v;
	logic [31:0] rd;
	int fails = 0;
	int checks = 0;
	int k;
	// Bytes 0x8F..0x9A; reserved deinit 1110b is clamped to 1101b
	logic [7:0] adv [12] = '{{3'h1, 5'h02}, {4'hD, 4'h4}, {1'h1, 7'h00}, 8'h46, 8'h00, 8'h12, 8'h34,
		8'h00, {7'h00, 1'h1}, 8'h00, {4'h1, 4'h0}, {4'h0, 4'h0}};
	mtca_if i_mtca_if (.clk(clk));
	mtca_host_end #(.DFLT_WAIT_US(12'h002)) i_mtca_host_end (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(i_mtca_if.host_mp));
	mtca_module_end #(.DEINIT_CODE(4'hE), .COOLED(1'h1), .LATENCY(16'h1234), .GLOBAL_OFF(1'h1))
		i_mtca_module_end (.clk(clk), .sys_rst(sys_rst), .ce(ce), .link(i_mtca_if.dev_mp),
		.tx_lane_output_off(lane_off), .tx_out_disabled(lane_dis));
	mtca_link_checker i_mtca_link_checker (.clk(clk), .sys_rst(sys_rst), .req(i_mtca_if.req), .wr(i_mtca_if.wr),
		.module_select_line(i_mtca_if.module_select_line), .addr(i_mtca_if.addr), .wdata(i_mtca_if.wdata),
		.ack(i_mtca_if.ack), .rdata(i_mtca_if.rdata));
	task automatic stop_test();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		bit got;
		got = 1'b0;
		r = 32'h0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Values read here are those the slave presented before this rising edge
		for (int n = 0; n < 16 && !got; n++) begin
			@(posedge clk);
			got = (pready === 1'b1);
			r = prdata;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (!got) begin
			fails++;
			stop_test();
		end
	endtask
	task automatic lk(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		logic [31:0] s;
		apb(1'b1, HREG_CTRL, {8'h00, d, a, 6'h00, w, 1'b1}, s);
		s = 32'h0;
		for (int n = 0; n < 3000 && s[STAT_DONE_BIT] !== 1'b1; n++)
			apb(1'b0, HREG_STATUS, 32'h0, s);
		if (s[STAT_DONE_BIT] !== 1'b1) begin
			fails++;
			stop_test();
		end
		apb(1'b1, HREG_STATUS, 32'h2, s);
		apb(1'b0, HREG_RDATA, 32'h0, r);
	endtask
	initial begin
		forever #4 clk = ~clk;
	end
	initial begin
		void'($urandom(32'h1d9ff57b));
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b0, HREG_STATUS, 32'h0, rd);
		chk(rd, 32'h0);
		apb(1'b0, HREG_WAIT, 32'h0, rd);
		chk(rd, 32'h2);
		lk(1'b0, OFS_SELECT_WAIT, 8'h00, rd);
		chk(rd, {24'h0, adv[0]});
		apb(1'b0, HREG_WAIT, 32'h0, rd);
		chk(rd, 32'(adv[0][4:0]) << adv[0][7:5]);
		apb(1'b0, HREG_STATUS, 32'h0, rd);
		chk(rd, 32'h4);
		for (k = 1; k < 12; k++) begin
			lk(1'b0, 8'(k + 8'h8F), 8'h00, rd);
			chk(rd, {24'h0, adv[k]});
		end
		lk(1'b1, OFS_CHAR_A, 8'($urandom()), rd);
		chk(rd, 32'h0);
		lk(1'b0, OFS_CHAR_A, 8'h00, rd);
		chk(rd, {24'h0, adv[2]});
		lk(1'b0, 8'h80, 8'h00, rd);
		chk(rd, 32'h0);
		for (k = 0; k < 9; k++) begin
			@(posedge clk);
			v = (k % 3 == 0) ? 8'h00 : (k % 3 == 1) ? 8'h01 << k : 8'($urandom());
			lane_off <= v;
			@(posedge clk);
			@(negedge clk);
			chk({24'h0, lane_dis}, (v != 8'h00) ? 32'hFF : 32'h0);
		end
		// Clock enable low must freeze the fan-out register
		@(posedge clk);
		lane_off <= 8'h10;
		@(posedge clk);
		ce <= 1'b0;
		lane_off <= 8'h00;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({24'h0, lane_dis}, 32'hFF);
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk({24'h0, lane_dis}, 32'h0);
		// Mid-run reset forgets the learned wait
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b0, HREG_STATUS, 32'h0, rd);
		chk(rd, 32'h0);
		apb(1'b0, HREG_WAIT, 32'h0, rd);
		chk(rd, 32'h2);
		stop_test();
	end
endmodule // module_timing_capability_advert_test
